/* mau_status_pkg.sv */
// Shared constants and types for the twisted-pair status and indication logic.
package mau_status_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 25;
  localparam int MS_NS          = 1_000_000;
  localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_DIV_W       = 16;

  // ****************************************************************
  // Millisecond intervals, counted in ticks
  // ****************************************************************
  localparam int MS_CNT_W = 10;
  localparam int STRETCH_MIN_MS = 20;
  localparam int UNJAB_MIN_MS   = 250;
  localparam int JABBER_MS      = 26;
  localparam int LINK_LOSS_MS   = 100;
  localparam int LINK_PULSE_MS  = 16;
  // One tick is added because the first tick after a start may come at once.
  localparam logic [MS_CNT_W-1:0] STRETCH_TICKS =
    MS_CNT_W'(STRETCH_MIN_MS + 1);
  localparam logic [MS_CNT_W-1:0] UNJAB_TICKS = MS_CNT_W'(UNJAB_MIN_MS + 1);
  localparam logic [MS_CNT_W-1:0] JABBER_TICKS = MS_CNT_W'(JABBER_MS);
  localparam logic [MS_CNT_W-1:0] LINK_LOSS_TICKS = MS_CNT_W'(LINK_LOSS_MS);
  localparam logic [MS_CNT_W-1:0] LINK_PULSE_TICKS =
    MS_CNT_W'(LINK_PULSE_MS);

  // ****************************************************************
  // Heartbeat and control-in pattern
  // ****************************************************************
  localparam int SQE_CNT_W    = 8;
  localparam int SQE_DELAY_NS = 1000;
  localparam int SQE_BURST_NS = 1000;
  localparam logic [SQE_CNT_W-1:0] SQE_DELAY_CYCLES =
    SQE_CNT_W'((SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SQE_CNT_W-1:0] SQE_BURST_CYCLES =
    SQE_CNT_W'(SQE_BURST_NS / CLK_PERIOD_NS);
  localparam int CI_PATTERN_PERIOD_NS = 100;
  localparam logic [1:0] CI_HALF_CYCLES =
    2'(CI_PATTERN_PERIOD_NS / (2 * CLK_PERIOD_NS));

  typedef enum logic [2:0] {
    HB_IDLE  = 3'b001,
    HB_WAIT  = 3'b010,
    HB_BURST = 3'b100
  } hb_state_type;

endpackage

/* ms_tick_divider.sv */
// Divider that makes a one-cycle enable pulse once per millisecond.
`timescale 1ns/100ps
`default_nettype none
module ms_tick_divider
  import mau_status_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic clr,
  // Tick
  output var  logic ms_tick
);

  logic [MS_DIV_W-1:0] div_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      div_reg <= '0;
      ms_tick <= 1'b0;
    end else if (div_reg == MS_DIV_W'(MS_TICK_CYCLES_P - 1)) begin
      div_reg <= '0;
      ms_tick <= 1'b1;
    end else begin
      div_reg <= MS_DIV_W'(div_reg + 1'b1);
      ms_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* pulse_stretcher.sv */
// Indicator driver that holds an active-low LED output past an activity end.
`timescale 1ns/100ps
`default_nettype none
module pulse_stretcher
  import mau_status_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic clr,
  input  wire logic ms_tick,
  // Activity and indicator
  input  wire logic active,
  output var  logic indicator_n
);

  logic [MS_CNT_W-1:0] hold_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      hold_reg <= '0;
    end else if (active) begin
      hold_reg <= STRETCH_TICKS;
    end else if (ms_tick && hold_reg != '0) begin
      hold_reg <= MS_CNT_W'(hold_reg - 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      indicator_n <= 1'b1;
    end else begin
      indicator_n <= ~(active | (hold_reg != '0));
    end
  end

endmodule
`default_nettype wire

/* tp_mau_status_indication.sv */
// Status, indication, jabber and link logic of a twisted-pair attachment unit.
//
// Contract
// - Collision is low while data-out and twisted-pair receive are active.
// - Overlong data-out activity enters jabber, which holds collision on.
// - Jabber and its pattern end after 250 to 750 ms of data-out silence.
// - The heartbeat burst on control-in never drives the collision indicator.
// - The collision indicator is held 20 to 62 ms after a collision ends.
// - Link-status strapped low disables monitoring and keeps paths active.
// - Idle link pulses are generated whatever the link-status pin shows.
// - Link status is low while the link is good and released once it fails.
// - A low power-down/reset input resets all logic and enters power-down.
// - During power-down/reset every output and indicator except power_down is inactive.
// - The receive indicator is low while twisted-pair data goes to data-in.
// - The receive indicator is low during a collision, alongside collision.
// - The receive indicator is held 20 to 62 ms after reception ends.
// - The transmit indicator is low while sending and 20 to 62 ms after.
// - The transmit indicator is asserted only outside link-fail and jabber; here a stretch begun before either still runs on into it.
`timescale 1ns/100ps
`default_nettype none
module tp_mau_status_indication
  import mau_status_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic power_down_reset_n,
  // Activity from the line receivers, already squelched
  input  wire logic do_active,
  input  wire logic rx_active,
  input  wire logic link_pulse_rx,
  // Straps
  input  wire logic sqe_test_enable_n,
  // Link-status open-drain pin
  input  wire logic link_status_n_in,
  output var  logic link_status_n_out,
  output var  logic link_status_n_oe,
  // Data path enables
  output var  logic transmit_enable,
  output var  logic receive_forward,
  output var  logic link_pulse_out,
  // Control-in pair
  output var  logic ci_active,
  output var  logic ci_level,
  // Indicators
  output logic      collision_indicator_n,
  output logic      receive_indicator_n,
  output logic      transmit_indicator_n,
  output var  logic power_down
);

  // ****************************************************************
  // Reset and time base
  // ****************************************************************
  logic clr;
  logic ms_tick;

  assign clr = sys_rst | ~power_down_reset_n;

  ms_tick_divider #(
    .MS_TICK_CYCLES_P (MS_TICK_CYCLES_P)
  ) u_tick (
    .sys_clk (sys_clk),
    .clr     (clr),
    .ms_tick (ms_tick)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= ~power_down_reset_n;
    end
  end

  // ****************************************************************
  // Link-status strap
  // ****************************************************************
  // The pin is read once in the first cycle after reset, while our own
  // driver is still off; later we may drive it low ourselves, so a strap
  // applied after reset is only seen at the next reset.
  logic strap_taken_reg;
  logic link_strap_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      strap_taken_reg <= 1'b0;
      link_strap_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      link_strap_reg  <= ~link_status_n_in;
    end
  end

  // ****************************************************************
  // Jabber and unjab
  // ****************************************************************
  logic                jabber_reg;
  logic [MS_CNT_W-1:0] jab_cnt_reg;
  logic [MS_CNT_W-1:0] unjab_cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      jab_cnt_reg <= '0;
    end else if (!do_active || jabber_reg) begin
      jab_cnt_reg <= '0;
    end else if (ms_tick) begin
      jab_cnt_reg <= MS_CNT_W'(jab_cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      unjab_cnt_reg <= '0;
    end else if (!jabber_reg || do_active) begin
      unjab_cnt_reg <= '0;
    end else if (ms_tick) begin
      unjab_cnt_reg <= MS_CNT_W'(unjab_cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      jabber_reg <= 1'b0;
    end else if (!jabber_reg && jab_cnt_reg >= JABBER_TICKS) begin
      jabber_reg <= 1'b1;
    end else if (jabber_reg && unjab_cnt_reg >= UNJAB_TICKS) begin
      jabber_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Link integrity
  // ****************************************************************
  logic                link_good_reg;
  logic [MS_CNT_W-1:0] loss_cnt_reg;
  logic                link_ok;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      loss_cnt_reg <= '0;
    end else if (link_pulse_rx || rx_active) begin
      loss_cnt_reg <= '0;
    end else if (ms_tick && loss_cnt_reg != LINK_LOSS_TICKS) begin
      loss_cnt_reg <= MS_CNT_W'(loss_cnt_reg + 1'b1);
    end
  end

  // Link is assumed good out of reset so that a quiet cable is given the
  // whole loss interval before it is declared failed.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      link_good_reg <= 1'b1;
    end else if (link_pulse_rx || rx_active) begin
      link_good_reg <= 1'b1;
    end else if (loss_cnt_reg == LINK_LOSS_TICKS) begin
      link_good_reg <= 1'b0;
    end
  end

  assign link_ok = link_good_reg | link_strap_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      link_status_n_out <= 1'b1;
      link_status_n_oe  <= 1'b0;
    end else begin
      link_status_n_out <= 1'b0;
      link_status_n_oe  <= link_ok;
    end
  end

  // ****************************************************************
  // Idle link pulse generation
  // ****************************************************************
  logic [MS_CNT_W-1:0] pulse_cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      pulse_cnt_reg  <= '0;
      link_pulse_out <= 1'b0;
    end else if (do_active) begin
      pulse_cnt_reg  <= '0;
      link_pulse_out <= 1'b0;
    end else if (ms_tick && pulse_cnt_reg == LINK_PULSE_TICKS - 1'b1) begin
      pulse_cnt_reg  <= '0;
      link_pulse_out <= 1'b1;
    end else begin
      if (ms_tick) begin
        pulse_cnt_reg <= MS_CNT_W'(pulse_cnt_reg + 1'b1);
      end
      link_pulse_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Data paths and collision
  // ****************************************************************
  logic col_raw;
  logic tx_path;
  logic rx_path;

  assign col_raw = do_active & rx_active;
  assign tx_path = do_active & ~jabber_reg & link_ok;
  assign rx_path = rx_active & link_ok;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      transmit_enable <= 1'b0;
      receive_forward <= 1'b0;
    end else begin
      transmit_enable <= tx_path;
      receive_forward <= rx_path;
    end
  end

  // ****************************************************************
  // Heartbeat after data-out ends
  // ****************************************************************
  hb_state_type         hb_state_reg;
  logic [SQE_CNT_W-1:0] hb_cnt_reg;
  logic                 do_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      do_prev_reg <= 1'b0;
    end else begin
      do_prev_reg <= do_active;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      hb_state_reg <= HB_IDLE;
      hb_cnt_reg   <= '0;
    end else begin
      unique case (hb_state_reg)
        HB_IDLE: begin
          hb_cnt_reg <= '0;
          if (do_prev_reg && !do_active && !jabber_reg &&
              !sqe_test_enable_n) begin
            hb_state_reg <= HB_WAIT;
          end
        end
        HB_WAIT: begin
          if (do_active || jabber_reg) begin
            hb_state_reg <= HB_IDLE;
          end else if (hb_cnt_reg == SQE_DELAY_CYCLES - 1'b1) begin
            hb_cnt_reg   <= '0;
            hb_state_reg <= HB_BURST;
          end else begin
            hb_cnt_reg <= SQE_CNT_W'(hb_cnt_reg + 1'b1);
          end
        end
        HB_BURST: begin
          if (hb_cnt_reg == SQE_BURST_CYCLES - 1'b1) begin
            hb_state_reg <= HB_IDLE;
          end else begin
            hb_cnt_reg <= SQE_CNT_W'(hb_cnt_reg + 1'b1);
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Control-in pattern
  // ****************************************************************
  logic       ci_want;
  logic [1:0] ci_half_reg;

  // The heartbeat reaches only the pair, never the collision LED.
  assign ci_want = col_raw | jabber_reg | (hb_state_reg == HB_BURST);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ci_active   <= 1'b0;
      ci_level    <= 1'b0;
      ci_half_reg <= '0;
    end else if (!ci_want) begin
      ci_active   <= 1'b0;
      ci_level    <= 1'b0;
      ci_half_reg <= '0;
    end else if (ci_half_reg == CI_HALF_CYCLES - 1'b1) begin
      ci_active   <= 1'b1;
      ci_level    <= ~ci_level;
      ci_half_reg <= '0;
    end else begin
      ci_active   <= 1'b1;
      ci_half_reg <= 2'(ci_half_reg + 1'b1);
    end
  end

  // ****************************************************************
  // Stretched indicators
  // ****************************************************************
  pulse_stretcher u_col_led (
    .sys_clk     (sys_clk),
    .clr         (clr),
    .ms_tick     (ms_tick),
    .active      (col_raw | jabber_reg),
    .indicator_n (collision_indicator_n)
  );

  pulse_stretcher u_rcv_led (
    .sys_clk     (sys_clk),
    .clr         (clr),
    .ms_tick     (ms_tick),
    .active      (rx_path | col_raw),
    .indicator_n (receive_indicator_n)
  );

  pulse_stretcher u_xmt_led (
    .sys_clk     (sys_clk),
    .clr         (clr),
    .ms_tick     (ms_tick),
    .active      (tx_path),
    .indicator_n (transmit_indicator_n)
  );

endmodule
`default_nettype wire

/* mau_status_properties.sv */
// Concurrent checks on the status and indication outputs.
`timescale 1ns/100ps
`default_nettype none
module mau_status_properties
  import mau_status_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
  // Watched ports
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic power_down_reset_n,
  input wire logic do_active,
  input wire logic rx_active,
  input wire logic link_status_n_out,
  input wire logic link_status_n_oe,
  input wire logic transmit_enable,
  input wire logic receive_forward,
  input wire logic ci_active,
  input wire logic ci_level,
  input wire logic collision_indicator_n,
  input wire logic receive_indicator_n,
  input wire logic transmit_indicator_n,
  input wire logic power_down
);
  logic        clr;
  logic [23:0] col_q_reg;
  logic [23:0] rx_q_reg;
  assign clr = sys_rst || !power_down_reset_n;
  // ********
  // Quiet time counters
  // ********
  // They saturate, so a long idle never wraps round to a short one.
  // A collision may end on either pair, so its hold is timed from the last
  // cycle with both active; after jabber that lies at least an unjab time back.
  always_ff @(posedge sys_clk) begin
    if (clr) col_q_reg <= '1;
    else if (do_active && rx_active) col_q_reg <= '0;
    else if (col_q_reg != '1) col_q_reg <= col_q_reg + 24'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (clr) rx_q_reg <= '1;
    else if (rx_active) rx_q_reg <= '0;
    else if (rx_q_reg != '1) rx_q_reg <= rx_q_reg + 24'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (clr);
  sequence s_flip;
    ci_active && $changed(ci_level) ##1 ci_active && $stable(ci_level);
  endsequence
  chk_col_both:
    assert property (do_active && rx_active |=>
      !collision_indicator_n && !receive_indicator_n)
    else $error("Collision or receive indicator not low.");
  chk_rcv_fwd:
    assert property (receive_forward |-> !receive_indicator_n)
    else $error("Receive indicator high while forwarding.");
  chk_xmt_fwd:
    assert property (transmit_enable |-> !transmit_indicator_n)
    else $error("Transmit indicator high while sending.");
  chk_pd_idle:
    assert property (disable iff (sys_rst) !power_down_reset_n |=>
      collision_indicator_n && receive_indicator_n &&
      transmit_indicator_n && link_status_n_out && !link_status_n_oe &&
      !ci_active && !transmit_enable && !receive_forward && power_down)
    else $error("Outputs not idle in power-down.");
  chk_link_drive:
    assert property (link_status_n_oe |-> !link_status_n_out)
    else $error("Link pin driven high.");
  chk_ci_period:
    assert property (s_flip ##1 ci_active |-> $changed(ci_level))
    else $error("Control-in pattern period wrong.");
  // The collision indicator can still fall from jabber two edges after data-out falls.
  chk_hb_quiet:
    assert property (!do_active && !$past(do_active) &&
      !$past(do_active, 2) && !rx_active && collision_indicator_n
      |=> collision_indicator_n)
    else $error("Collision indicator set without cause.");
  chk_col_hold:
    assert property ($rose(collision_indicator_n) |->
      col_q_reg + 2 >= 20 * MS_TICK_CYCLES_P)
    else $error("Collision indicator released early.");
  chk_rcv_hold:
    assert property ($rose(receive_indicator_n) |->
      rx_q_reg + 2 >= 20 * MS_TICK_CYCLES_P &&
      rx_q_reg <= 62 * MS_TICK_CYCLES_P)
    else $error("Receive indicator stretch wrong.");
endmodule
bind tp_mau_status_indication mau_status_properties #(
  .MS_TICK_CYCLES_P(MS_TICK_CYCLES_P)
) chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst),
  .power_down_reset_n(power_down_reset_n), .do_active(do_active),
  .rx_active(rx_active), .link_status_n_out(link_status_n_out),
  .link_status_n_oe(link_status_n_oe), .transmit_enable(transmit_enable),
  .receive_forward(receive_forward), .ci_active(ci_active),
  .ci_level(ci_level), .collision_indicator_n(collision_indicator_n),
  .receive_indicator_n(receive_indicator_n),
  .transmit_indicator_n(transmit_indicator_n), .power_down(power_down)
);
`default_nettype wire

/* link_partner_model.sv */
// Model of the cabled link partner and of the link-status pin wiring.
`timescale 1ns/100ps
`default_nettype none
module link_partner_model #(
  parameter int unsigned PULSE_GAP = 320
) (
  // Clock and bench controls
  input  wire logic sys_clk,
  input  wire logic pulses_on,
  input  wire logic strap_low,
  // Link-status pin
  input  wire logic pin_drive_oe,
  input  wire logic pin_drive_out,
  output var  logic pin_level,
  // Idle pulses from the far end
  output var  logic link_pulse_rx
);
  int unsigned gap_reg;
  // The pin has a pull-up, so a released pin reads high.
  assign pin_level = strap_low ? 1'b0 :
                     (pin_drive_oe ? pin_drive_out : 1'b1);
  always_ff @(posedge sys_clk) begin
    gap_reg <= (gap_reg >= PULSE_GAP) ? 0 : gap_reg + 1;
    link_pulse_rx <= pulses_on && (gap_reg == PULSE_GAP);
  end
endmodule
`default_nettype wire

/* tb_tp_mau_status_indication.sv */
// Self-checking bench for the status and indication logic.
`timescale 1ns/100ps
`default_nettype none
module tb_tp_mau_status_indication;
  import mau_status_pkg::*;
  // A short millisecond keeps the unjab wait within the run budget.
  localparam int P = 40;
  logic sys_clk = 1'b0;
  logic sys_rst, power_down_reset_n, do_active, rx_active, sqe_test_enable_n;
  logic pulses_on, strap_low, link_pulse_rx, link_status_n_in;
  logic link_status_n_out, link_status_n_oe, transmit_enable;
  logic receive_forward, link_pulse_out, ci_active, ci_level;
  logic collision_indicator_n, receive_indicator_n, transmit_indicator_n;
  logic power_down;
  int   err_total = 0;
  int   checks = 0;
  int   lp_cnt = 0;
  int   lp_base;
  initial forever #12.5 sys_clk = ~sys_clk;
  tp_mau_status_indication #(.MS_TICK_CYCLES_P(P)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .power_down_reset_n(power_down_reset_n), .do_active(do_active),
    .rx_active(rx_active), .link_pulse_rx(link_pulse_rx),
    .sqe_test_enable_n(sqe_test_enable_n),
    .link_status_n_in(link_status_n_in),
    .link_status_n_out(link_status_n_out),
    .link_status_n_oe(link_status_n_oe), .transmit_enable(transmit_enable),
    .receive_forward(receive_forward), .link_pulse_out(link_pulse_out),
    .ci_active(ci_active), .ci_level(ci_level),
    .collision_indicator_n(collision_indicator_n),
    .receive_indicator_n(receive_indicator_n),
    .transmit_indicator_n(transmit_indicator_n), .power_down(power_down)
  );
  link_partner_model partner (
    .sys_clk(sys_clk), .pulses_on(pulses_on), .strap_low(strap_low),
    .pin_drive_oe(link_status_n_oe), .pin_drive_out(link_status_n_out),
    .pin_level(link_status_n_in), .link_pulse_rx(link_pulse_rx)
  );
  always_ff @(posedge sys_clk) begin
    if (link_pulse_out === 1'b1) lp_cnt <= lp_cnt + 1;
  end
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic drive(input logic d, input logic r, input int n);
    @(posedge sys_clk);
    do_active <= d;
    rx_active <= r;
    wait_cyc(n);
  endtask
  task automatic results;
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    results;
  end
  initial begin
    sys_rst <= 1'b1;
    power_down_reset_n <= 1'b1;
    do_active <= 1'b0;
    rx_active <= 1'b0;
    sqe_test_enable_n <= 1'b0;
    pulses_on <= 1'b1;
    strap_low <= 1'b0;
    wait_cyc(8);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_cyc(4);
    check(link_status_n_in, 1'b0);
    drive(1'b1, 1'b0, 20);
    check(transmit_enable, 1'b1);
    check(transmit_indicator_n, 1'b0);
    drive(1'b0, 1'b0, 1);
    for (int i = 0; i < 120 && ci_active !== 1'b1; i++) wait_cyc(1);
    check(ci_active, 1'b1);
    check(collision_indicator_n, 1'b1);
    wait_cyc(18 * P);
    check(transmit_indicator_n, 1'b0);
    wait_cyc(5 * P);
    check(transmit_indicator_n, 1'b1);
    drive(1'b1, 1'b1, 10);
    check(collision_indicator_n, 1'b0);
    check(receive_indicator_n, 1'b0);
    drive(1'b0, 1'b0, 18 * P);
    check(collision_indicator_n, 1'b0);
    check(receive_indicator_n, 1'b0);
    wait_cyc(5 * P);
    check(collision_indicator_n, 1'b1);
    check(receive_indicator_n, 1'b1);
    drive(1'b0, 1'b1, 10);
    check(receive_forward, 1'b1);
    check(receive_indicator_n, 1'b0);
    check(collision_indicator_n, 1'b1);
    drive(1'b0, 1'b0, 25 * P);
    drive(1'b1, 1'b0, 30 * P);
    check(collision_indicator_n, 1'b0);
    check(ci_active, 1'b1);
    check(transmit_enable, 1'b0);
    drive(1'b0, 1'b0, 200 * P);
    check(ci_active, 1'b1);
    check(collision_indicator_n, 1'b0);
    wait_cyc(60 * P);
    check(ci_active, 1'b0);
    check(collision_indicator_n, 1'b0);
    wait_cyc(25 * P);
    check(collision_indicator_n, 1'b1);
    @(posedge sys_clk);
    pulses_on <= 1'b0;
    lp_base = lp_cnt;
    wait_cyc(110 * P);
    check(link_status_n_oe, 1'b0);
    check(link_status_n_in, 1'b1);
    check(lp_cnt != lp_base, 1'b1);
    drive(1'b1, 1'b0, 10);
    check(transmit_enable, 1'b0);
    check(transmit_indicator_n, 1'b1);
    drive(1'b0, 1'b0, 2);
    @(posedge sys_clk);
    pulses_on <= 1'b1;
    wait_cyc(20 * P);
    check(link_status_n_oe, 1'b1);
    @(posedge sys_clk);
    power_down_reset_n <= 1'b0;
    strap_low <= 1'b1;
    do_active <= 1'b1;
    rx_active <= 1'b1;
    wait_cyc(3);
    check(power_down, 1'b1);
    check(collision_indicator_n, 1'b1);
    check(link_status_n_oe, 1'b0);
    check(ci_active, 1'b0);
    @(posedge sys_clk);
    power_down_reset_n <= 1'b1;
    pulses_on <= 1'b0;
    sqe_test_enable_n <= 1'b1;
    drive(1'b0, 1'b0, 110 * P);
    drive(1'b1, 1'b0, 10);
    check(transmit_enable, 1'b1);
    drive(1'b0, 1'b0, 60);
    check(ci_active, 1'b0);
    results;
  end
endmodule
`default_nettype wire
